/* common/timer_pkg.sv */
// shared constants for the dual timer/counter block
package timer_pkg;
    // ************************************************
    // special function register addresses
    // ************************************************
    localparam int          SFR_ADDR_WIDTH = 8;
    localparam int          SFR_DATA_WIDTH = 8;
    localparam logic [7:0]  ADDR_CTRL      = 8'h88;
    localparam logic [7:0]  ADDR_MODE      = 8'h89;
    localparam logic [7:0]  ADDR_T0_LOW    = 8'h8a;
    localparam logic [7:0]  ADDR_T1_LOW    = 8'h8b;
    localparam logic [7:0]  ADDR_T0_HIGH   = 8'h8c;
    localparam logic [7:0]  ADDR_T1_HIGH   = 8'h8d;

    // ************************************************
    // control/status bit positions
    // ************************************************
    localparam int          CTRL_T1_OVF    = 7;
    localparam int          CTRL_T1_RUN    = 6;
    localparam int          CTRL_T0_OVF    = 5;
    localparam int          CTRL_T0_RUN    = 4;
    localparam int          CTRL_B_FLAG    = 3;
    localparam int          CTRL_B_TRIG    = 2;
    localparam int          CTRL_A_FLAG    = 1;
    localparam int          CTRL_A_TRIG    = 0;

    // ************************************************
    // mode register layout (one nibble per timer)
    // ************************************************
    localparam int          MODE_T1_LSB    = 4;
    localparam int          MODE_T0_LSB    = 0;
    localparam int          FIELD_GATE     = 3;
    localparam int          FIELD_COUNTER  = 2;
    localparam int          FIELD_MODE_LSB = 0;

    // ************************************************
    // reset values and timing
    // ************************************************
    localparam logic [7:0]  CTRL_RESET     = 8'h00;
    localparam logic [7:0]  MODE_RESET     = 8'h00;
    localparam logic [7:0]  COUNT_RESET    = 8'h00;
    localparam int          CLOCKS_PER_MC  = 12;
    localparam int          PRESCALE_BITS  = 5;

    typedef enum logic [1:0] {
        MODE_PRESCALE13 = 2'b00,
        MODE_CASCADE16  = 2'b01,
        MODE_RELOAD8    = 2'b10,
        MODE_SPLIT      = 2'b11
    } timer_mode_type;
endpackage

/* core/pin_sync.sv */
// two-stage synchroniser for a group of pin inputs
module pin_sync #(
    parameter int WIDTH = 4
) (
    input  wire logic             clock,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sync_state_type;

    sync_state_type s_q;
    sync_state_type s_d;

    // first stage feeds only the second
    always_comb
    begin
        s_d        = s_q;
        s_d.stage1 = async_in;
        s_d.stage2 = s_q.stage1;
    end

    // state register
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            s_q <= '1;   // pins idle high, no false edge
        else
            s_q <= s_d;
    end

    assign sync_out = s_q.stage2;
endmodule // pin_sync

/* core/cycle_strobe.sv */
// machine cycle strobe: one pulse every DIVIDE core clocks
module cycle_strobe #(
    parameter int DIVIDE = 12
) (
    input  wire logic clock,
    input  wire logic resetn,
    output logic      strobe
);
    localparam int CW = $clog2(DIVIDE);
    localparam logic [CW-1:0] LAST = CW'(DIVIDE - 1);

    typedef struct packed {
        logic [CW-1:0] count;
        logic          pulse;
    } strobe_state_type;

    strobe_state_type s_q;
    strobe_state_type s_d;

    // wrap counter, pulse on terminal count
    always_comb
    begin
        s_d       = s_q;
        s_d.pulse = (s_q.count == LAST);
        if (s_q.count == LAST)
            s_d.count = '0;
        else
            s_d.count = s_q.count + CW'(1);
    end

    // state register
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign strobe = s_q.pulse;
endmodule // cycle_strobe

/* core/dual_timer_counter.sv */
// two 8051-style timer/counters with external interrupt flags
// ************************************************
// Functional notes
// ************************************************
//
// Functional notes
// - mode field picks prescale, cascade, reload, split
// - mode 0 counts high byte plus five bits
// - wrap to zero sets the overflow flag, except timer 1 wraps while timer 0 splits
// - count only if run (timer 1: run or timer 0 split) and gate/pin allow
// - setting run leaves counts untouched
// - mode 1 counts full sixteen bits
// - mode 2 reloads low from high
// - timer 1 in split mode holds
// - timer 0 split: high byte uses timer 1 run bit and flag
// - timer 1 still counts while timer 0 splits
// - timer 1 flag set on overflow (timer 0 high byte while timer 0 splits), cleared on vector
// - timer 0 flag set on overflow, cleared on vector
// - bits 6 and 4 are run bits
// - interrupt b flag: edge or low level
// - interrupt a flag behaves the same
// - bit 2 selects edge for interrupt b
// - bit 0 selects edge for interrupt a
// - timer function counts every twelve clocks
// - counter samples pin each machine cycle
// - mode register holds both timer nibbles
module dual_timer_counter
    import timer_pkg::*;
#(
    parameter int MACHINE_CYCLE_CLOCKS = timer_pkg::CLOCKS_PER_MC
) (
    input  wire logic                                CLOCK,
    input  wire logic                                RESETN,
    input  wire logic [timer_pkg::SFR_ADDR_WIDTH-1:0] SFR_ADDR,
    input  wire logic                                SFR_WR_EN,
    input  wire logic [timer_pkg::SFR_DATA_WIDTH-1:0] SFR_WR_DATA,
    input  wire logic                                SFR_RD_EN,
    output logic      [timer_pkg::SFR_DATA_WIDTH-1:0] SFR_RD_DATA,
    output logic                                     SFR_RD_VALID,
    input  wire logic                                COUNT_INPUT_A_PIN,
    input  wire logic                                COUNT_INPUT_B_PIN,
    input  wire logic                                EXT_IRQ_A_PIN,
    input  wire logic                                EXT_IRQ_B_PIN,
    input  wire logic                                TIMER0_VECTOR_ACK,
    input  wire logic                                TIMER1_VECTOR_ACK,
    input  wire logic                                EXT_A_VECTOR_ACK,
    input  wire logic                                EXT_B_VECTOR_ACK,
    output logic                                     TIMER0_OVERFLOW_FLAG,
    output logic                                     TIMER1_OVERFLOW_FLAG,
    output logic                                     EXT_IRQ_A_FLAG,
    output logic                                     EXT_IRQ_B_FLAG,
    output logic                                     TIMER1_OVERFLOW_PULSE
);
    import timer_pkg::*;

    // ************************************************
    // state
    // ************************************************
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] mode;
        logic [7:0] t0_low;
        logic [7:0] t0_high;
        logic [7:0] t1_low;
        logic [7:0] t1_high;
        logic [1:0] count_sample;  // last machine-cycle pin sample
        logic [1:0] count_pending; // fall seen, count next cycle
        logic [1:0] irq_prev;      // previous irq pin level
        logic       t1_pulse;
        logic [7:0] rd_data;
        logic       rd_valid;
    } timer_state_type;

    timer_state_type s_q;
    timer_state_type s_d;

    logic [3:0] pins_sync;
    logic       mc_strobe;

    // ************************************************
    // count step: {overflow, high, low}
    // ************************************************
    function automatic logic [16:0] count_step(
        input logic [1:0] mode,
        input logic [7:0] low,
        input logic [7:0] high,
        input logic       inc
    );
        logic [16:0] r;
        logic [13:0] c13;
        logic [16:0] c16;
        logic [8:0]  c8;
        r   = {1'b0, high, low};
        c13 = {1'b0, high, low[PRESCALE_BITS-1:0]} + 14'h0001;
        c16 = {1'b0, high, low} + 17'h00001;
        c8  = {1'b0, low} + 9'h001;
        if (inc)
        begin
            case (timer_mode_type'(mode))
                MODE_PRESCALE13:
                    r = {c13[13], c13[12:5], low[7:5], c13[4:0]};
                MODE_CASCADE16:
                    r = c16;
                MODE_RELOAD8:
                    r = {c8[8], high, (c8[8] ? high : c8[7:0])};
                default:
                    r = {c8[8], high, c8[7:0]};
            endcase
        end
        return r;
    endfunction

    // ************************************************
    // pin synchronisers and machine cycle
    // ************************************************
    pin_sync #(
        .WIDTH (4)
    ) u_pin_sync (
        .clock    (CLOCK),
        .resetn   (RESETN),
        .async_in ({EXT_IRQ_B_PIN, EXT_IRQ_A_PIN,
                    COUNT_INPUT_B_PIN, COUNT_INPUT_A_PIN}),
        .sync_out (pins_sync)
    );

    cycle_strobe #(
        .DIVIDE (MACHINE_CYCLE_CLOCKS)
    ) u_cycle_strobe (
        .clock  (CLOCK),
        .resetn (RESETN),
        .strobe (mc_strobe)
    );

    // ************************************************
    // next state
    // ************************************************
    always_comb
    begin
        logic [1:0]  count_pin;
        logic [1:0]  irq_pin;
        logic [1:0]  count_edge;
        logic [3:0]  nib0;
        logic [3:0]  nib1;
        logic        split0;
        logic        run0;
        logic        run1;
        logic        tick0;
        logic        tick1;
        logic        high0_tick;
        logic [8:0]  high0_next;
        logic [16:0] step0;
        logic [16:0] step1;
        logic        ovf0;
        logic        ovf1;
        logic [1:0]  irq_fall;

        s_d        = s_q;
        count_pin  = pins_sync[1:0];
        irq_pin    = pins_sync[3:2];
        nib0       = s_q.mode[MODE_T0_LSB +: 4];
        nib1       = s_q.mode[MODE_T1_LSB +: 4];
        split0     = (nib0[FIELD_MODE_LSB +: 2] == MODE_SPLIT);
        count_edge = s_q.count_pending & {2{mc_strobe}};
        irq_fall   = s_q.irq_prev & ~irq_pin;
        // remaining locals start cleared
        run0       = 1'b0;
        run1       = 1'b0;
        tick0      = 1'b0;
        tick1      = 1'b0;
        high0_tick = 1'b0;
        high0_next = 9'h000;
        step0      = 17'h00000;
        step1      = 17'h00000;
        ovf0       = 1'b0;
        ovf1       = 1'b0;

        // ************************************************
        // counting
        // ************************************************
        // sample once per machine cycle
        if (mc_strobe)
        begin
            s_d.count_sample  = count_pin;
            s_d.count_pending = s_q.count_sample & ~count_pin;
        end
        s_d.irq_prev = irq_pin;

        run0 = s_q.ctrl[CTRL_T0_RUN] &
               (~nib0[FIELD_GATE] | irq_pin[0]);
        // split hands run bit to timer 0 high byte
        run1 = (s_q.ctrl[CTRL_T1_RUN] | split0) &
               (~nib1[FIELD_GATE] | irq_pin[1]) &
               (nib1[FIELD_MODE_LSB +: 2] != MODE_SPLIT);
        tick0 = run0 & (nib0[FIELD_COUNTER] ? count_edge[0] : mc_strobe);
        tick1 = run1 & (nib1[FIELD_COUNTER] ? count_edge[1] : mc_strobe);

        step0 = count_step(nib0[FIELD_MODE_LSB +: 2],
                           s_q.t0_low, s_q.t0_high, tick0);
        step1 = count_step(nib1[FIELD_MODE_LSB +: 2],
                           s_q.t1_low, s_q.t1_high, tick1);

        // split high byte counts cycles on timer 1 run
        high0_tick = split0 & s_q.ctrl[CTRL_T1_RUN] & mc_strobe;
        high0_next = {1'b0, s_q.t0_high} + 9'h001;

        s_d.t0_low  = step0[7:0];
        s_d.t0_high = step0[15:8];
        if (high0_tick)
            s_d.t0_high = high0_next[7:0];
        s_d.t1_low  = step1[7:0];
        s_d.t1_high = step1[15:8];

        ovf0 = step0[16];
        // timer 1 flag goes to split high byte
        ovf1 = split0 ? (high0_tick & high0_next[8]) : step1[16];
        // timer 1 wrap still drives baud pulse
        s_d.t1_pulse = step1[16];

        // ************************************************
        // software access
        // ************************************************
        // software byte write wins over counting; flag updates below win over a control write
        if (SFR_WR_EN)
        begin
            if (SFR_ADDR == ADDR_T0_LOW)
                s_d.t0_low = SFR_WR_DATA;
            else if (SFR_ADDR == ADDR_T0_HIGH)
                s_d.t0_high = SFR_WR_DATA;
            else if (SFR_ADDR == ADDR_T1_LOW)
                s_d.t1_low = SFR_WR_DATA;
            else if (SFR_ADDR == ADDR_T1_HIGH)
                s_d.t1_high = SFR_WR_DATA;
            else if (SFR_ADDR == ADDR_MODE)
                s_d.mode = SFR_WR_DATA;
            else if (SFR_ADDR == ADDR_CTRL)
                s_d.ctrl = SFR_WR_DATA;
        end

        // ************************************************
        // flags
        // ************************************************
        // vector clears timer 0 flag
        if (TIMER0_VECTOR_ACK)
            s_d.ctrl[CTRL_T0_OVF] = 1'b0;
        if (TIMER1_VECTOR_ACK)
            s_d.ctrl[CTRL_T1_OVF] = 1'b0;
        if (ovf0)
            s_d.ctrl[CTRL_T0_OVF] = 1'b1;
        if (ovf1)
            s_d.ctrl[CTRL_T1_OVF] = 1'b1;

        // edge or level for interrupt a
        if (s_q.ctrl[CTRL_A_TRIG])
        begin
            if (EXT_A_VECTOR_ACK)
                s_d.ctrl[CTRL_A_FLAG] = 1'b0;
            if (irq_fall[0])
                s_d.ctrl[CTRL_A_FLAG] = 1'b1;
        end
        else
            s_d.ctrl[CTRL_A_FLAG] = ~irq_pin[0];

        // edge or level for interrupt b
        if (s_q.ctrl[CTRL_B_TRIG])
        begin
            if (EXT_B_VECTOR_ACK)
                s_d.ctrl[CTRL_B_FLAG] = 1'b0;
            if (irq_fall[1])
                s_d.ctrl[CTRL_B_FLAG] = 1'b1;
        end
        else
            s_d.ctrl[CTRL_B_FLAG] = ~irq_pin[1];

        // register read, unmapped reads zero
        s_d.rd_valid = SFR_RD_EN;
        s_d.rd_data  = 8'h00;
        if (SFR_RD_EN)
        begin
            if (SFR_ADDR == ADDR_CTRL)
                s_d.rd_data = s_q.ctrl;
            else if (SFR_ADDR == ADDR_MODE)
                s_d.rd_data = s_q.mode;
            else if (SFR_ADDR == ADDR_T0_LOW)
                s_d.rd_data = s_q.t0_low;
            else if (SFR_ADDR == ADDR_T0_HIGH)
                s_d.rd_data = s_q.t0_high;
            else if (SFR_ADDR == ADDR_T1_LOW)
                s_d.rd_data = s_q.t1_low;
            else if (SFR_ADDR == ADDR_T1_HIGH)
                s_d.rd_data = s_q.t1_high;
        end
    end

    // ************************************************
    // state register
    // ************************************************
    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            s_q          <= '0;
            s_q.ctrl     <= CTRL_RESET;
            s_q.mode     <= MODE_RESET;
            s_q.t0_low   <= COUNT_RESET;
            s_q.t0_high  <= COUNT_RESET;
            s_q.t1_low   <= COUNT_RESET;
            s_q.t1_high  <= COUNT_RESET;
            s_q.irq_prev <= 2'h3;   // idle high, no false edge
        end
        else
            s_q <= s_d;
    end

    // ************************************************
    // outputs
    // ************************************************
    assign SFR_RD_DATA           = s_q.rd_data;
    assign SFR_RD_VALID          = s_q.rd_valid;
    assign TIMER0_OVERFLOW_FLAG  = s_q.ctrl[CTRL_T0_OVF];
    assign TIMER1_OVERFLOW_FLAG  = s_q.ctrl[CTRL_T1_OVF];
    assign EXT_IRQ_A_FLAG        = s_q.ctrl[CTRL_A_FLAG];
    assign EXT_IRQ_B_FLAG        = s_q.ctrl[CTRL_B_FLAG];
    assign TIMER1_OVERFLOW_PULSE = s_q.t1_pulse;
endmodule // dual_timer_counter

/* tb/dual_timer_counter_assertions.sv */
// concurrent checks on the timer block's register and flag ports
// ************************************************
// checker
// ************************************************
module dual_timer_counter_checker #(
    parameter int MACHINE_CYCLE_CLOCKS = 12
) (
    input wire logic       CLOCK,
    input wire logic       RESETN,
    input wire logic [7:0] SFR_ADDR,
    input wire logic       SFR_WR_EN,
    input wire logic [7:0] SFR_WR_DATA,
    input wire logic       SFR_RD_EN,
    input wire logic [7:0] SFR_RD_DATA,
    input wire logic       SFR_RD_VALID,
    input wire logic       EXT_IRQ_A_PIN,
    input wire logic       EXT_IRQ_B_PIN,
    input wire logic       TIMER0_VECTOR_ACK,
    input wire logic       TIMER1_VECTOR_ACK,
    input wire logic       TIMER0_OVERFLOW_FLAG,
    input wire logic       TIMER1_OVERFLOW_FLAG,
    input wire logic       EXT_IRQ_A_FLAG,
    input wire logic       EXT_IRQ_B_FLAG
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] ctl_q;   // run1, run0, trig b, trig a
    logic [7:0] since_q; // clocks since reset or control write
    logic [7:0] idle0_q; // clocks since timer 0 run bit was last set
    logic [7:0] idle1_q; // clocks since timer 1 run bit was last set
    wire        ctrl_wr = SFR_WR_EN && SFR_ADDR == 8'h88;
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RESETN);

    // shadow of the software control bits and quiet-time counters
    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            ctl_q   <= 4'h0;
            since_q <= 8'h00;
            idle0_q <= 8'h00;
            idle1_q <= 8'h00;
        end
        else
        begin
            if (ctrl_wr)
                ctl_q <= {SFR_WR_DATA[6], SFR_WR_DATA[4], SFR_WR_DATA[2], SFR_WR_DATA[0]};
            since_q <= ctrl_wr ? 8'h00 : since_q + {7'h00, since_q != 8'hff};
            idle0_q <= (ctrl_wr && SFR_WR_DATA[4]) || ctl_q[2] ? 8'h00 : idle0_q + {7'h00, idle0_q != 8'hff};
            idle1_q <= (ctrl_wr && SFR_WR_DATA[6]) || ctl_q[3] ? 8'h00 : idle1_q + {7'h00, idle1_q != 8'hff};
        end
    end

    a_read_valid_next: assert property (
        SFR_RD_VALID == $past(SFR_RD_EN)) else $error("read valid misplaced");
    a_read_data_idle: assert property (
        !SFR_RD_VALID |-> SFR_RD_DATA == 8'h00) else $error("read data not zero when idle");
    a_ctrl_flag_bits: assert property (
        SFR_RD_EN && SFR_ADDR == 8'h88 |=> SFR_RD_DATA[7] == $past(TIMER1_OVERFLOW_FLAG)
        && SFR_RD_DATA[5] == $past(TIMER0_OVERFLOW_FLAG) && SFR_RD_DATA[3] == $past(EXT_IRQ_B_FLAG)
        && SFR_RD_DATA[1] == $past(EXT_IRQ_A_FLAG)) else $error("control flags differ from flag ports");
    a_ctrl_run_bits: assert property (
        SFR_RD_EN && SFR_ADDR == 8'h88 |=> {SFR_RD_DATA[6], SFR_RD_DATA[4], SFR_RD_DATA[2], SFR_RD_DATA[0]}
        == $past(ctl_q)) else $error("control run or trigger bits lost");
    a_t0_ack_clears: assert property (
        TIMER0_VECTOR_ACK && !ctrl_wr && idle0_q >= 3 * MACHINE_CYCLE_CLOCKS |=> !TIMER0_OVERFLOW_FLAG)
        else $error("timer 0 flag survived its vector");
    a_t1_ack_clears: assert property (
        TIMER1_VECTOR_ACK && !ctrl_wr && idle1_q >= 3 * MACHINE_CYCLE_CLOCKS |=> !TIMER1_OVERFLOW_FLAG)
        else $error("timer 1 flag survived its vector");
    a_level_a_follows: assert property (
        since_q >= 8'd6 && !ctl_q[0] |-> EXT_IRQ_A_FLAG == !$past(EXT_IRQ_A_PIN, 3))
        else $error("level flag a does not follow its pin");
    a_level_b_follows: assert property (
        since_q >= 8'd6 && !ctl_q[1] |-> EXT_IRQ_B_FLAG == !$past(EXT_IRQ_B_PIN, 3))
        else $error("level flag b does not follow its pin");
    a_edge_a_sets: assert property (
        since_q >= 8'd6 && ctl_q[0] && $past(EXT_IRQ_A_PIN, 4) && !$past(EXT_IRQ_A_PIN, 3)
        |-> ##[0:2] EXT_IRQ_A_FLAG) else $error("falling edge missed on pin a");
endmodule // dual_timer_counter_checker

bind dual_timer_counter dual_timer_counter_checker #(.MACHINE_CYCLE_CLOCKS(MACHINE_CYCLE_CLOCKS)) u_checker (
    .CLOCK(CLOCK), .RESETN(RESETN), .SFR_ADDR(SFR_ADDR), .SFR_WR_EN(SFR_WR_EN), .SFR_WR_DATA(SFR_WR_DATA),
    .SFR_RD_EN(SFR_RD_EN), .SFR_RD_DATA(SFR_RD_DATA), .SFR_RD_VALID(SFR_RD_VALID),
    .EXT_IRQ_A_PIN(EXT_IRQ_A_PIN), .EXT_IRQ_B_PIN(EXT_IRQ_B_PIN),
    .TIMER0_VECTOR_ACK(TIMER0_VECTOR_ACK), .TIMER1_VECTOR_ACK(TIMER1_VECTOR_ACK),
    .TIMER0_OVERFLOW_FLAG(TIMER0_OVERFLOW_FLAG), .TIMER1_OVERFLOW_FLAG(TIMER1_OVERFLOW_FLAG),
    .EXT_IRQ_A_FLAG(EXT_IRQ_A_FLAG), .EXT_IRQ_B_FLAG(EXT_IRQ_B_FLAG)
);

/* tb/count_pin_source.sv */
// external count pin source standing outside the timer block
// ************************************************
// count pin source
// ************************************************
module count_pin_source (
    input  wire logic       clock,
    input  wire logic       enable,
    input  wire logic [7:0] half_clocks,
    output logic            pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] left_q = 8'h00;
    initial pin = 1'b1;
    always @(posedge clock)
    begin
        #1;
        if (!enable || left_q <= 8'h01)
        begin
            pin = pin ^ enable;
            left_q = half_clocks;
        end
        else
            left_q = left_q - 8'h01;
    end
endmodule // count_pin_source

/* tb/dual_timer_counter_tb.sv */
// self-checking bench for the dual timer/counter block
module dual_timer_counter_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MC = 4; // shortened machine cycle
    logic       CLOCK = 1'b0;
    logic       RESETN = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic       wr_en = 1'b0;
    logic       rd_en = 1'b0;
    logic [1:0] irq_pin = 2'b11;
    logic [3:0] ack = 4'h0; // timer 0, timer 1, ext a, ext b
    logic [1:0] cnt_en = 2'b00;
    logic [7:0] half = 8'h05;
    wire  [7:0] rdata;
    wire        rd_valid;
    wire        pulse1;
    wire  [1:0] cnt_pin;
    wire  [1:0] flag_t;
    wire  [1:0] flag_e;
    wire  [4:0] ev = {pulse1, flag_e, flag_t};
    int         bad_count = 0;
    int         tests_run = 0;
    int         falls [2] = '{0, 0};

    // ************************************************
    // clock, design and pin sources
    // ************************************************
    always #2.5 CLOCK = !CLOCK;
    always @(negedge cnt_pin[0]) falls[0]++;
    always @(negedge cnt_pin[1]) falls[1]++;
    dual_timer_counter #(.MACHINE_CYCLE_CLOCKS(MC)) u_dual_timer_counter (
        .CLOCK(CLOCK), .RESETN(RESETN), .SFR_ADDR(addr), .SFR_WR_EN(wr_en), .SFR_WR_DATA(wdata),
        .SFR_RD_EN(rd_en), .SFR_RD_DATA(rdata), .SFR_RD_VALID(rd_valid),
        .COUNT_INPUT_A_PIN(cnt_pin[0]), .COUNT_INPUT_B_PIN(cnt_pin[1]),
        .EXT_IRQ_A_PIN(irq_pin[0]), .EXT_IRQ_B_PIN(irq_pin[1]), .TIMER0_VECTOR_ACK(ack[0]),
        .TIMER1_VECTOR_ACK(ack[1]), .EXT_A_VECTOR_ACK(ack[2]), .EXT_B_VECTOR_ACK(ack[3]),
        .TIMER0_OVERFLOW_FLAG(flag_t[0]), .TIMER1_OVERFLOW_FLAG(flag_t[1]), .EXT_IRQ_A_FLAG(flag_e[0]),
        .EXT_IRQ_B_FLAG(flag_e[1]), .TIMER1_OVERFLOW_PULSE(pulse1));
    count_pin_source u_count_pin_source_a (.clock(CLOCK), .enable(cnt_en[0]), .half_clocks(half), .pin(cnt_pin[0]));
    count_pin_source u_count_pin_source_b (.clock(CLOCK), .enable(cnt_en[1]), .half_clocks(half), .pin(cnt_pin[1]));

    // ************************************************
    // bus, wait and compare tasks
    // ************************************************
    task automatic idle(input int n);
        repeat (n) @(posedge CLOCK);
        #1;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        idle(1);
        addr = a;
        wdata = v;
        wr_en = 1'b1;
        idle(1);
        wr_en = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        idle(1);
        addr = a;
        rd_en = 1'b1;
        idle(1);
        rd_en = 1'b0;
        chk({7'h00, rd_valid}, 8'h01);
        v = rdata;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        rd(a, v);
        chk(v, e);
    endtask
    task automatic pulse_ack(input int k);
        ack[k] = 1'b1;
        idle(1);
        ack[k] = 1'b0;
    endtask
    task automatic wait_ev(input int b);
        for (int n = 0; n < 3000 && ev[b] !== 1'b1; n++)
            idle(1);
        if (ev[b] !== 1'b1)
        begin
            chk({7'h00, ev[b]}, 8'h01);
            wrap_up();
        end
    endtask
    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // ************************************************
    // scenarios
    // ************************************************
    initial
    begin
        logic [7:0] d, hi, base;
        int t, m, i;
        void'($urandom(38));
        idle(4);
        RESETN = 1'b1;
        idle(6);
        for (i = 8'h86; i < 8'h90; i++)
            rd_chk(8'(i), 8'h00);
        $display("test reset values done");
        for (i = 0; i < 8; i++)
        begin
            addr = 8'h89 + 8'($urandom_range(4));
            d = 8'($urandom);
            wr(addr, d);
            rd_chk(addr, d);
        end
        $display("test register access done");
        // modes 0 to 2 each wrap at their width
        for (t = 0; t < 2; t++)
            for (m = 0; m < 3; m++)
            begin
                hi = (m == 2) ? 8'($urandom) : 8'hff;
                wr(8'h88, 8'h00);
                wr(8'h89, 8'(m << (4 * t)));
                wr(8'h8c + 8'(t), hi);
                wr(8'h8a + 8'(t), 8'hfe);
                wr(8'h88, t ? 8'h40 : 8'h10);
                wait_ev(t);
                wr(8'h88, t ? 8'h80 : 8'h20);
                base = (m == 2) ? hi : 8'h00;
                rd_chk(8'h8c + 8'(t), base);
                rd(8'h8a + 8'(t), d);
                if (m == 0)
                    base = 8'he0; // upper low bits held
                chk({7'h00, 8'(d - base) <= 8'h01}, 8'h01);
                idle(4 * MC);
                pulse_ack(t);
                chk({7'h00, flag_t[t]}, 8'h00);
            end
        $display("test timer modes done");
        wr(8'h89, 8'h09);
        wr(8'h8a, 8'h00);
        irq_pin[0] = 1'b0;
        wr(8'h88, 8'h10);
        idle(8 * MC);
        rd_chk(8'h8a, 8'h00);
        irq_pin[0] = 1'b1;
        idle(8 * MC);
        rd(8'h8a, d);
        chk({7'h00, d > 8'h04}, 8'h01);
        $display("test gating done");
        // split mode high byte on run1
        wr(8'h88, 8'h00);
        wr(8'h89, 8'h33);
        wr(8'h8a, 8'h77);
        wr(8'h8b, 8'h55);
        wr(8'h8c, 8'hfe);
        wr(8'h88, 8'h40);
        wait_ev(1);
        wr(8'h88, 8'h80);
        rd_chk(8'h8a, 8'h77);
        rd_chk(8'h8b, 8'h55);
        wr(8'h89, 8'h03);
        wr(8'h8d, 8'hff);
        wr(8'h8b, 8'h1e);
        wait_ev(4);
        rd_chk(8'h8c, 8'h00);
        $display("test split mode done");
        for (t = 0; t < 2; t++)
        begin
            wr(8'h88, 8'h00);
            wr(8'h89, t ? 8'h50 : 8'h05);
            wr(8'h8a + 8'(t), 8'h00);
            wr(8'h88, t ? 8'h40 : 8'h10);
            half = 8'(MC + 1 + $urandom_range(3));
            falls[t] = 0;
            cnt_en[t] = 1'b1;
            idle(40 * MC);
            cnt_en[t] = 1'b0;
            idle(4 * MC);
            wr(8'h88, 8'h00);
            rd_chk(8'h8a + 8'(t), 8'(falls[t]));
        end
        $display("test counter function done");
        for (i = 0; i < 2; i++)
        begin
            wr(8'h88, i ? 8'h04 : 8'h01);
            idle(4);
            irq_pin[i] = 1'b0;
            idle(6);
            chk({7'h00, flag_e[i]}, 8'h01);
            irq_pin[i] = 1'b1;
            pulse_ack(2 + i);
            chk({7'h00, flag_e[i]}, 8'h00);
            wr(8'h88, 8'h00);
            irq_pin[i] = 1'b0;
            idle(6);
            pulse_ack(2 + i);
            chk({7'h00, flag_e[i]}, 8'h01);
            irq_pin[i] = 1'b1;
            idle(6);
            chk({7'h00, flag_e[i]}, 8'h00);
        end
        $display("test external flags done");
        wrap_up();
    end
endmodule // dual_timer_counter_tb
